// file: rtl/etr_ctrl.sv
// Emulation probe trigger, switch-off, power-fail restore and ECU reset control
`timescale 1ns/100ps
module etr_ctrl
    import etr_pkg::*;
#(
    parameter int BOOT_W = BOOT_CFG_W
)(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  bus_cs_n,
    input  wire logic                  bus_we_n,
    input  wire logic [etr_pkg::ADDR_W-1:0] bus_addr,
    input  wire logic [etr_pkg::SEG_W-1:0]  trig_seg_base,
    input  wire logic                  power_fail_long,
    input  wire logic                  flash_copy_done,
    input  wire logic                  host_data_loaded,
    input  wire logic                  ecu_supply_sense,
    input  wire logic                  external_reset_line_a_n,
    input  wire logic                  external_reset_line_b_n,
    input  wire logic                  reset_sense_jumper,
    input  wire logic                  init_done,
    input  wire logic                  power_save,
    input  wire logic                  tool_reset_req,
    input  wire logic                  device_fault,
    input  wire logic                  bdf_start,
    input  wire logic                  bdf_code_loaded,
    input  wire logic                  bdf_prog_done,
    input  wire logic                  power_on_reset_line_n_in,
    output logic [etr_pkg::NUM_TRIG-1:0] trig_pulse,
    output logic                       switched_off,
    output logic                       tool_access_en,
    output logic                       power_fail_record,
    output logic                       flash_copy_start,
    output logic                       green_led,
    output logic                       ecu_off,
    output logic                       write_protect,
    output logic                       power_on_reset_line_n_out,
    output logic                       power_on_reset_line_n_oe,
    output logic [BOOT_W-1:0]          boot_config_inputs_out,
    output logic                       boot_config_inputs_oe,
    output logic                       boot_chip_select_map
);
    import etr_pkg::*;

    etr_evt_if evt ();

    etr_bdf_state_t bdf_state;
    etr_bdf_state_t next_bdf_state;
    logic [8:0]     hold_cnt;
    logic           hold_done;
    logic           copy_busy;
    logic           por_req;
    logic           sensed_reset_n;

    etr_trig_decode u_decode (
        .clk      (clk),
        .reset_n  (reset_n),
        .bus_cs_n (bus_cs_n),
        .bus_we_n (bus_we_n),
        .bus_addr (bus_addr),
        .seg_base (trig_seg_base),
        .evt      (evt)
    );

    // Acquisition start pulses, one cycle per trigger write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_pulse <= '0;
        end else begin
            trig_pulse <= '0;
            if (evt.trig_valid) begin
                trig_pulse[evt.trig_num] <= 1'b1;
            end
        end
    end

    // Switch-off state; triggers keep running while off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            switched_off   <= 1'b0;
            tool_access_en <= 1'b1;
        end else begin
            if (evt.off_hit) begin
                switched_off   <= 1'b1;
                tool_access_en <= 1'b0;
            end else if (evt.on_hit) begin
                switched_off   <= 1'b0;
                tool_access_en <= 1'b1;
            end
        end
    end

    // Power failure record; a new failure wins over the clear at copy end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            power_fail_record <= 1'b0;
        end else if (power_fail_long) begin
            power_fail_record <= 1'b1;
        end else if (copy_busy && flash_copy_done) begin
            power_fail_record <= 1'b0;
        end
    end

    // Flash to both emulation pages once initialization has finished
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            copy_busy        <= 1'b0;
            flash_copy_start <= 1'b0;
        end else begin
            flash_copy_start <= 1'b0;
            if (!copy_busy && power_fail_record && init_done && !power_fail_long) begin
                copy_busy        <= 1'b1;
                flash_copy_start <= 1'b1;
            end else if (copy_busy && flash_copy_done) begin
                copy_busy <= 1'b0;
            end
        end
    end

    // Green indicator stays lit until the tool loads fresh data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            green_led <= 1'b0;
        end else if (flash_copy_start || copy_busy) begin
            green_led <= 1'b1;
        end else if (host_data_loaded) begin
            green_led <= 1'b0;
        end
    end

    // Supply and reset line sensing
    assign sensed_reset_n = (reset_sense_jumper == JUMPER_LINE_B) ?
                            external_reset_line_b_n : external_reset_line_a_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ecu_off       <= 1'b1;
            write_protect <= 1'b1;
        end else begin
            ecu_off       <= !ecu_supply_sense;
            write_protect <= !sensed_reset_n;
        end
    end

    // Braindead flashing sequence
    assign hold_done = (hold_cnt == RST_HOLD_LAST);

    always_comb begin
        next_bdf_state = bdf_state;
        case (bdf_state)
            BDF_IDLE: begin
                if (bdf_start) begin
                    next_bdf_state = BDF_HOLD;
                end
            end
            BDF_HOLD: begin
                if (hold_done) begin
                    next_bdf_state = BDF_LOAD;
                end
            end
            BDF_LOAD: begin
                if (bdf_code_loaded) begin
                    next_bdf_state = BDF_RUN;
                end
            end
            BDF_RUN: begin
                if (bdf_prog_done) begin
                    next_bdf_state = BDF_FINAL;
                end
            end
            BDF_FINAL: begin
                if (hold_done) begin
                    next_bdf_state = BDF_IDLE;
                end
            end
            default: begin
                next_bdf_state = BDF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bdf_state <= BDF_IDLE;
        end else begin
            bdf_state <= next_bdf_state;
        end
    end

    // Minimum reset pulse, restarted on every state change
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_cnt <= 9'h000;
        end else if (next_bdf_state != bdf_state || hold_done) begin
            hold_cnt <= 9'h000;
        end else if (bdf_state == BDF_HOLD || bdf_state == BDF_FINAL) begin
            hold_cnt <= hold_cnt + 9'h001;
        end
    end

    // Boot override: external boot from the reset pulse until programming ends
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            boot_config_inputs_oe  <= 1'b0;
            boot_config_inputs_out <= '0;
            boot_chip_select_map   <= 1'b0;
        end else begin
            boot_config_inputs_oe  <= (next_bdf_state == BDF_HOLD) ||
                                      (next_bdf_state == BDF_LOAD) ||
                                      (next_bdf_state == BDF_RUN);
            boot_config_inputs_out <= BOOT_W'(BOOT_CFG_EXT);
            boot_chip_select_map   <= (next_bdf_state == BDF_LOAD) ||
                                      (next_bdf_state == BDF_RUN);
        end
    end

    // Power-on reset is open drain, pulled low while any reason stands
    assign por_req = power_save || !init_done || tool_reset_req || device_fault ||
                     (bdf_state == BDF_HOLD) || (bdf_state == BDF_LOAD) ||
                     (bdf_state == BDF_FINAL);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            power_on_reset_line_n_oe  <= 1'b1;
            power_on_reset_line_n_out <= 1'b0;
        end else begin
            power_on_reset_line_n_oe  <= por_req;
            power_on_reset_line_n_out <= 1'b0;
        end
    end

    // Checks
    sequence s_bdf_begin;
        bdf_state == BDF_IDLE && bdf_start;
    endsequence

    sequence s_prog_end;
        bdf_state == BDF_RUN && bdf_prog_done;
    endsequence

    a_switch_off_set: assert property (@(posedge clk) disable iff (!reset_n)
        evt.off_hit |=> switched_off && !tool_access_en)
        else $error("switch-off write not honoured");

    a_reactivate_clr: assert property (@(posedge clk) disable iff (!reset_n)
        evt.on_hit |=> !switched_off && tool_access_en)
        else $error("reactivation write not honoured");

    a_off_still_triggers: assert property (@(posedge clk) disable iff (!reset_n)
        switched_off && evt.trig_valid |=> trig_pulse[$past(evt.trig_num)])
        else $error("trigger lost while switched off");

    a_trig_one_hot: assert property (@(posedge clk) disable iff (!reset_n)
        trig_pulse != '0 |-> $onehot(trig_pulse) && $past(evt.trig_valid))
        else $error("trigger pulse without cause");

    a_fail_recorded: assert property (@(posedge clk) disable iff (!reset_n)
        power_fail_long |=> power_fail_record)
        else $error("power failure not recorded");

    a_restore_green: assert property (@(posedge clk) disable iff (!reset_n)
        (flash_copy_start || copy_busy) |=> green_led)
        else $error("green indicator not lit during restore");

    a_copy_after_fail: assert property (@(posedge clk) disable iff (!reset_n)
        flash_copy_start |-> power_fail_record && copy_busy)
        else $error("restore started without a recorded failure");

    a_bdf_reset_first: assert property (@(posedge clk) disable iff (!reset_n)
        s_bdf_begin |=> ##1 power_on_reset_line_n_oe && boot_config_inputs_oe
            && !boot_chip_select_map)
        else $error("braindead flash did not start with reset");

    a_bdf_ext_boot: assert property (@(posedge clk) disable iff (!reset_n)
        bdf_state == BDF_LOAD |=> boot_config_inputs_oe
            && boot_config_inputs_out == BOOT_W'(BOOT_CFG_EXT))
        else $error("boot configuration not driven");

    a_bdf_release: assert property (@(posedge clk) disable iff (!reset_n)
        s_prog_end |=> !boot_config_inputs_oe ##1 power_on_reset_line_n_oe)
        else $error("final reset or boot release missing");

    a_run_holds: assert property (@(posedge clk) disable iff (!reset_n)
        bdf_state == BDF_RUN && !bdf_prog_done |=> bdf_state == BDF_RUN)
        else $error("recovery run left before programming ended");

    a_por_init: assert property (@(posedge clk) disable iff (!reset_n)
        (!init_done || power_save) |=> power_on_reset_line_n_oe)
        else $error("reset not held before initialization");

    a_por_tool: assert property (@(posedge clk) disable iff (!reset_n)
        (tool_reset_req || device_fault) |=> power_on_reset_line_n_oe
            && !power_on_reset_line_n_out)
        else $error("tool or fault reset not asserted");

    a_wp_follow: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) |-> write_protect == $past(reset_sense_jumper
            ? !external_reset_line_b_n : !external_reset_line_a_n))
        else $error("write protect does not follow selected line");

    a_ecu_off_seen: assert property (@(posedge clk) disable iff (!reset_n)
        !ecu_supply_sense [*2] |-> ecu_off)
        else $error("ECU off not reported");
endmodule : etr_ctrl

// file: rtl/etr_pkg.sv
// Constants and types for the emulation trigger and reset control block
// What this block does
// - Thirty-two separate trigger addresses, trigger 0 to 31, each start their own task.
// - A comparator selects a 256-byte aligned trigger segment at a configurable base.
// - A write to segment base plus 0x04 enters the switch-off state.
// - A write to the segment base itself leaves the switch-off state.
// - Data carried by switch-off and reactivation writes is ignored.
// - Switched off, the block keeps working but reports off and refuses tool access.
// - Power failures are detected and recorded so inconsistent emulation data is known.
// - After a long failure, flash is copied into both pages with green indicator lit.
// - Braindead flashing starts by forcing the microcontroller into reset.
// - During braindead flashing the boot configuration inputs select external boot.
// - In external boot the boot chip select maps here and recovery code runs.
// - After programming, reset again and release the boot configuration override.
// - The ECU supply sense input shows when the ECU is off; report it.
// - Write protect for emulation memory follows the sensed external reset line.
// - Hold power-on reset in power save and until own initialization finishes.
// - Reset can also be asserted on tool command and on own failure.
// - Jumper 1-2 senses reset line b; 2-3, the default, senses line a.
// - The memory is reached over a 32-bit bus with one chip select.
package etr_pkg;
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          ADDR_W          = 20;
    localparam int          SEG_SHIFT       = 8;
    localparam int          SEG_W           = ADDR_W - SEG_SHIFT;
    localparam int          NUM_TRIG        = 32;
    localparam int          TRIG_W          = 5;
    localparam logic [7:0]  REACTIVATE_OFS  = 8'h00;
    localparam logic [7:0]  SWITCH_OFF_OFS  = 8'h04;
    localparam logic [7:0]  TRIG_OFS_BASE   = 8'h80;
    localparam int          BOOT_CFG_W      = 4;
    localparam logic [3:0]  BOOT_CFG_EXT    = 4'h1;
    localparam logic        JUMPER_LINE_B   = 1'b1;
    localparam int          RST_HOLD_NS     = 10000;
    localparam int          RST_HOLD_CYC    = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [8:0]  RST_HOLD_LAST   = 9'(RST_HOLD_CYC - 1);

    typedef enum logic [2:0] {
        BDF_IDLE  = 3'h0,
        BDF_HOLD  = 3'h1,
        BDF_LOAD  = 3'h3,
        BDF_RUN   = 3'h2,
        BDF_FINAL = 3'h6
    } etr_bdf_state_t;
endpackage : etr_pkg

// file: rtl/etr_evt_if.sv
// Decoded trigger segment events passed from the decoder to the controller
`timescale 1ns/100ps
interface etr_evt_if;
    logic       trig_valid;
    logic [4:0] trig_num;
    logic       off_hit;
    logic       on_hit;

    modport dec (output trig_valid, output trig_num, output off_hit, output on_hit);
    modport ctl (input trig_valid, input trig_num, input off_hit, input on_hit);
endinterface : etr_evt_if

// file: rtl/etr_trig_decode.sv
// Trigger segment address decoder for chip-selected bus writes
`timescale 1ns/100ps
module etr_trig_decode
    import etr_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 bus_cs_n,
    input  wire logic                 bus_we_n,
    input  wire logic [ADDR_W-1:0]    bus_addr,
    input  wire logic [SEG_W-1:0]     seg_base,
    etr_evt_if.dec                    evt
);
    logic       wr;
    logic       seg_hit;
    logic [7:0] ofs;

    // Only the address is looked at; bus data never reaches this block
    assign wr      = !bus_cs_n && !bus_we_n;
    assign seg_hit = wr && (bus_addr[ADDR_W-1:SEG_SHIFT] == seg_base);
    assign ofs     = bus_addr[SEG_SHIFT-1:0];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            evt.trig_valid <= 1'b0;
            evt.trig_num   <= 5'h00;
            evt.off_hit    <= 1'b0;
            evt.on_hit     <= 1'b0;
        end else begin
            // Triggers sit one word apart from the top half of the segment
            evt.trig_valid <= seg_hit && ofs[7] && (ofs[1:0] == 2'h0);
            evt.trig_num   <= ofs[6:2];
            evt.off_hit    <= seg_hit && (ofs == SWITCH_OFF_OFS);
            evt.on_hit     <= seg_hit && (ofs == REACTIVATE_OFS);
        end
    end

    sequence s_trig_write;
        !bus_cs_n && !bus_we_n && bus_addr[ADDR_W-1:SEG_SHIFT] == seg_base
            && bus_addr[7:0] >= TRIG_OFS_BASE && bus_addr[1:0] == 2'h0;
    endsequence

    a_trig_write_hit: assert property (@(posedge clk) disable iff (!reset_n)
        s_trig_write |=> evt.trig_valid && evt.trig_num == $past(bus_addr[6:2]))
        else $error("trigger write not decoded");

    a_other_seg_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        (bus_cs_n || bus_addr[ADDR_W-1:SEG_SHIFT] != seg_base)
            |=> !evt.trig_valid && !evt.off_hit && !evt.on_hit)
        else $error("event outside the trigger segment");

    a_event_single: assert property (@(posedge clk) disable iff (!reset_n)
        evt.off_hit |-> $past(!bus_cs_n && !bus_we_n
            && bus_addr == {seg_base, SWITCH_OFF_OFS}))
        else $error("switch-off event longer than its write");
endmodule : etr_trig_decode

// file: bench/etr_ecu_model.sv
// Behavioural ECU microcontroller on the probe's bus and reset pins
`timescale 1ns/100ps
module etr_ecu_model (
    input  wire logic                   clk,
    input  wire logic                   power_on_reset_line_n_out,
    input  wire logic                   power_on_reset_line_n_oe,
    output logic                        power_on_reset_line_n_in,
    output logic                        bus_cs_n,
    output logic                        bus_we_n,
    output logic [etr_pkg::ADDR_W-1:0]  bus_addr,
    output logic                        ecu_supply_sense,
    output logic                        external_reset_line_a_n,
    output logic                        external_reset_line_b_n
);
    import etr_pkg::*;

    // Open-drain reset line, pulled up when nobody drives it low
    assign power_on_reset_line_n_in = power_on_reset_line_n_oe ? power_on_reset_line_n_out : 1'b1;

    initial begin
        bus_cs_n = 1'b1;
        bus_we_n = 1'b1;
        bus_addr = '0;
        ecu_supply_sense = 1'b1;
        external_reset_line_a_n = 1'b1;
        external_reset_line_b_n = 1'b1;
    end

    // One access on the single chip select; the address stays in the 1 MB window
    task bus_acc(input logic [ADDR_W-1:0] a, input logic wr);
        @(posedge clk);
        #1;
        bus_cs_n = 1'b0;
        bus_we_n = ~wr;
        bus_addr = a;
        @(posedge clk);
        #1;
        bus_cs_n = 1'b1;
        bus_we_n = 1'b1;
        // Released address lines show no stale value
        bus_addr = ~a;
    endtask : bus_acc
endmodule : etr_ecu_model

// file: bench/tb_emulation_trigger_reset_control.sv
// Self-checking bench for the trigger, switch-off, restore and reset control
`timescale 1ns/100ps
module tb_emulation_trigger_reset_control;
    import etr_pkg::*;

    logic clk, reset_n, bus_cs_n, bus_we_n, power_fail_long, flash_copy_done;
    logic host_data_loaded, ecu_supply_sense, external_reset_line_a_n;
    logic external_reset_line_b_n, reset_sense_jumper, init_done, power_save;
    logic tool_reset_req, device_fault, bdf_start, bdf_code_loaded, bdf_prog_done;
    logic power_on_reset_line_n_in, switched_off, tool_access_en, power_fail_record;
    logic flash_copy_start, green_led, ecu_off, write_protect;
    logic power_on_reset_line_n_out, power_on_reset_line_n_oe;
    logic boot_config_inputs_oe, boot_chip_select_map;
    logic [ADDR_W-1:0]     bus_addr;
    logic [SEG_W-1:0]      trig_seg_base;
    logic [NUM_TRIG-1:0]   trig_pulse;
    logic [BOOT_CFG_W-1:0] boot_config_inputs_out;
    int                    bad_count, tests_run, cyc;

    etr_ctrl i_dut (
        .clk, .reset_n, .bus_cs_n, .bus_we_n, .bus_addr, .trig_seg_base,
        .power_fail_long, .flash_copy_done, .host_data_loaded, .ecu_supply_sense,
        .external_reset_line_a_n, .external_reset_line_b_n, .reset_sense_jumper,
        .init_done, .power_save, .tool_reset_req, .device_fault, .bdf_start,
        .bdf_code_loaded, .bdf_prog_done, .power_on_reset_line_n_in, .trig_pulse,
        .switched_off, .tool_access_en, .power_fail_record, .flash_copy_start,
        .green_led, .ecu_off, .write_protect, .power_on_reset_line_n_out,
        .power_on_reset_line_n_oe, .boot_config_inputs_out, .boot_config_inputs_oe,
        .boot_chip_select_map
    );

    etr_ecu_model i_ecu (
        .clk, .power_on_reset_line_n_out, .power_on_reset_line_n_oe,
        .power_on_reset_line_n_in, .bus_cs_n, .bus_we_n, .bus_addr,
        .ecu_supply_sense, .external_reset_line_a_n, .external_reset_line_b_n
    );

    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Stimulus and sampling both sit 1 ns after the rising edge
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task trig_one(input int n);
        i_ecu.bus_acc({trig_seg_base, TRIG_OFS_BASE + 8'(4 * n)}, 1'b1);
        tick(1);
        chk(trig_pulse, 32'h1 << n);
        tick(1);
        chk(trig_pulse, 32'h0);
    endtask : trig_one

    task resv_one(input logic [ADDR_W-1:0] a, input logic wr);
        i_ecu.bus_acc(a, wr);
        tick(1);
        chk(trig_pulse, 32'h0);
        chk(switched_off, 1'b0);
    endtask : resv_one

    task t_trig;
        for (int n = 0; n < NUM_TRIG; n++) begin
            trig_one(n);
        end
        resv_one({trig_seg_base, 8'h08}, 1'b1);
        resv_one({trig_seg_base, 8'h7c}, 1'b1);
        resv_one({trig_seg_base + 12'h001, 8'h84}, 1'b1);
        resv_one({trig_seg_base, 8'h84}, 1'b0);
        resv_one({trig_seg_base, SWITCH_OFF_OFS}, 1'b0);
        $display("test triggers done");
    endtask : t_trig

    // Bus data is not a port, so only the address can act
    task t_switch;
        i_ecu.bus_acc({trig_seg_base, SWITCH_OFF_OFS}, 1'b1);
        tick(2);
        chk(switched_off, 1'b1);
        chk(tool_access_en, 1'b0);
        trig_one(7);
        i_ecu.bus_acc({trig_seg_base, REACTIVATE_OFS}, 1'b1);
        tick(2);
        chk(switched_off, 1'b0);
        chk(tool_access_en, 1'b1);
        $display("test switch-off done");
    endtask : t_switch

    task t_restore;
        power_fail_long = 1'b1;
        tick(1);
        power_fail_long = 1'b0;
        chk(power_fail_record, 1'b1);
        for (int i = 0; i < 8 && flash_copy_start !== 1'b1; i++) tick(1);
        chk(flash_copy_start, 1'b1);
        tick(1);
        chk(flash_copy_start, 1'b0);
        chk(green_led, 1'b1);
        chk(power_fail_record, 1'b1);
        flash_copy_done = 1'b1;
        tick(1);
        flash_copy_done = 1'b0;
        tick(1);
        chk(power_fail_record, 1'b0);
        chk(green_led, 1'b1);
        host_data_loaded = 1'b1;
        tick(1);
        host_data_loaded = 1'b0;
        tick(1);
        chk(green_led, 1'b0);
        $display("test restore done");
    endtask : t_restore

    task t_levels;
        i_ecu.ecu_supply_sense = 1'b0;
        tick(1);
        chk(ecu_off, 1'b1);
        i_ecu.ecu_supply_sense = 1'b1;
        tick(1);
        chk(ecu_off, 1'b0);
        for (int j = 0; j < 2; j++) begin
            reset_sense_jumper = j[0];
            for (int k = 0; k < 4; k++) begin
                i_ecu.external_reset_line_a_n = k[0];
                i_ecu.external_reset_line_b_n = k[1];
                tick(1);
                chk(write_protect, (j == 1) ? !k[1] : !k[0]);
            end
        end
        reset_sense_jumper = 1'b0;
        $display("test levels done");
    endtask : t_levels

    task t_por;
        for (int s = 0; s < 4; s++) begin
            {device_fault, tool_reset_req, power_save, init_done} = 4'h1 ^ (4'h1 << s);
            tick(1);
            chk(power_on_reset_line_n_oe, 1'b1);
            chk(power_on_reset_line_n_out, 1'b0);
            {device_fault, tool_reset_req, power_save, init_done} = 4'h1;
            tick(1);
            chk(power_on_reset_line_n_oe, 1'b0);
        end
        $display("test ecu reset done");
    endtask : t_por

    task t_bdf;
        int c;
        bdf_start = 1'b1;
        tick(1);
        bdf_start = 1'b0;
        tick(1);
        chk(power_on_reset_line_n_oe, 1'b1);
        chk(boot_config_inputs_oe, 1'b1);
        chk(boot_config_inputs_out, BOOT_CFG_EXT);
        c = 0;
        repeat (RST_HOLD_CYC + 20) begin
            tick(1);
            if (power_on_reset_line_n_oe === 1'b1) c++;
        end
        chk(c, RST_HOLD_CYC + 20);
        bdf_code_loaded = 1'b1;
        tick(1);
        bdf_code_loaded = 1'b0;
        for (int i = 0; i < 8 && power_on_reset_line_n_oe !== 1'b0; i++) tick(1);
        chk(power_on_reset_line_n_in, 1'b1);
        chk(boot_config_inputs_oe, 1'b1);
        chk(boot_config_inputs_out, BOOT_CFG_EXT);
        chk(boot_chip_select_map, 1'b1);
        bdf_start = 1'b1;
        tick(1);
        bdf_start = 1'b0;
        tick(2);
        chk(power_on_reset_line_n_oe, 1'b0);
        bdf_prog_done = 1'b1;
        c = 0;
        repeat (RST_HOLD_CYC + 50) begin
            tick(1);
            bdf_prog_done = 1'b0;
            if (power_on_reset_line_n_oe === 1'b1) c++;
        end
        chk(c, RST_HOLD_CYC);
        chk(boot_config_inputs_oe, 1'b0);
        chk(boot_chip_select_map, 1'b0);
        $display("test braindead flashing done");
    endtask : t_bdf

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Hang guard sized well above the longest run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            $display("timeout at %0t", $time);
            end_sim;
        end
    end

    initial begin
        {power_fail_long, flash_copy_done, host_data_loaded, reset_sense_jumper} = '0;
        {power_save, tool_reset_req, device_fault} = '0;
        {bdf_start, bdf_code_loaded, bdf_prog_done} = '0;
        init_done = 1'b1;
        trig_seg_base = 12'h5a3;
        reset_n = 1'b0;
        repeat (10) @(posedge clk);
        chk(power_on_reset_line_n_oe, 1'b1);
        chk(tool_access_en, 1'b1);
        chk(trig_pulse, 32'h0);
        chk(boot_config_inputs_oe, 1'b0);
        #1;
        reset_n = 1'b1;
        tick(1);
        t_trig;
        t_switch;
        t_restore;
        t_levels;
        t_por;
        t_bdf;
        end_sim;
    end
endmodule : tb_emulation_trigger_reset_control
